// ===== ashs_params.svh
// Constants of the sample-and-hold sequencer and its controller
`ifndef ASHS_PARAMS_SVH
`define ASHS_PARAMS_SVH
`define ASHS_CLK_MHZ 50
`define ASHS_CONV_US 100
`define ASHS_SETTLE_US 30
`define ASHS_CONV_CYCLES (`ASHS_CONV_US * `ASHS_CLK_MHZ)
`define ASHS_SETTLE_CYCLES (`ASHS_SETTLE_US * `ASHS_CLK_MHZ)
`define ASHS_IO_HOLD 8'h90
`define ASHS_IO_START 8'hA0
`define ASHS_MEM_HOLD 16'h6090
`define ASHS_MEM_START 16'h60A0
`define ASHS_IO_HIGH 8'h00
`define ASHS_ZERO_MV 14'h03E8
`define ASHS_MV_STEP 14'h0014
`define ASHS_CODE_MAX 8'hFF
`define ASHS_EOC_BIT 4
`define ASHS_REG_CTRL 3'h0
`define ASHS_REG_STATUS 3'h1
`define ASHS_REG_RESULT 3'h2
`define ASHS_REG_INT_STATUS 3'h3
`define ASHS_REG_INT_MASK 3'h4
`define ASHS_CTRL_GO 0
`define ASHS_CTRL_CHAN_LO 1
`define ASHS_CTRL_CHAN_HI 2
`define ASHS_CTRL_MEM 3
`define ASHS_INT_DONE 0
`endif

// ===== ashs_pkg.sv
// Types shared by both ends of the sequencer link
package ashs_pkg;
	typedef enum logic [1:0] {ASHS_TRACK, ASHS_HELD, ASHS_CONV} ashs_dev_state_t;
	typedef enum logic [2:0] {ASHS_IDLE, ASHS_SETTLE, ASHS_HOLD, ASHS_START, ASHS_GAP, ASHS_POLL, ASHS_READ,
		ASHS_CAPT} ashs_host_state_t;
	typedef logic [13:0] ashs_mv_t;
	typedef logic [7:0] ashs_code_t;
endpackage

// ===== ashs_bus_if.sv
// Processor I/O bus, channel select and port status between the two ends
`timescale 1ns/1ns
interface ashs_bus_if;
	logic [15:0] io_addr;
	logic io_mem;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic chan_sel_low;
	logic chan_sel_high;
	logic [7:0] port_c_in;
	modport device (input io_addr, io_mem, io_wr, io_rd, io_wdata, chan_sel_low, chan_sel_high,
		output io_rdata, port_c_in);
	modport host (output io_addr, io_mem, io_wr, io_rd, io_wdata, chan_sel_low, chan_sel_high,
		input io_rdata, port_c_in);
endinterface

// ===== ashs_device.sv
// Sample-and-hold, multiplexer and 8-bit converter sequencing, device end
`timescale 1ns/1ns
`include "ashs_params.svh"
module ashs_device
	import ashs_pkg::*;
#(
	parameter int CONV_CYCLES = `ASHS_CONV_CYCLES
)
(
	input wire logic clk, // 50 MHz clock
	input wire logic reset_n, // Synchronous reset
	ashs_bus_if.device bus, // Processor bus side
	input wire logic [3:0][13:0] ain_mv, // Analog inputs in millivolts
	input wire logic mmio_en, // Memory-mapped option strap
	output logic sh_hold, // Sample-and-hold in hold
	output logic adc_busy // Conversion running
);
	localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES - 1);

	function automatic logic addr_hit(input logic [15:0] addr, input logic mem, input logic map_en,
		input logic [7:0] io_off, input logic [15:0] mem_off);
		if (mem)
			addr_hit = map_en && (addr == mem_off);
		else
			addr_hit = (addr[7:0] == io_off);
	endfunction

	function automatic ashs_code_t mv_to_code(input ashs_mv_t mv);
		ashs_mv_t steps;
		steps = 14'h0000;
		if (mv <= `ASHS_ZERO_MV)
			mv_to_code = 8'h00;
		else
		begin
			steps = (mv - `ASHS_ZERO_MV) / `ASHS_MV_STEP;
			if (steps > 14'(`ASHS_CODE_MAX))
				mv_to_code = `ASHS_CODE_MAX;
			else
				mv_to_code = steps[7:0];
		end
	endfunction

	// Analog words change asynchronously; a word is taken only after two equal samples past the synchroniser
	logic [3:0][13:0] ain_s1;
	logic [3:0][13:0] ain_s2;
	logic [3:0][13:0] ain_s3;
	logic [3:0][13:0] ain_ok;
	logic map_s1;
	logic map_s2;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (!reset_n)
				begin
					ain_s1[g] <= 14'h0000;
					ain_s2[g] <= 14'h0000;
					ain_s3[g] <= 14'h0000;
					ain_ok[g] <= 14'h0000;
				end
				else
				begin
					ain_s1[g] <= ain_mv[g];
					ain_s2[g] <= ain_s1[g];
					ain_s3[g] <= ain_s2[g];
					// A word caught mid-change differs from its neighbour; keep the last settled one
					if (ain_s2[g] == ain_s3[g])
						ain_ok[g] <= ain_s3[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			map_s1 <= 1'b0;
			map_s2 <= 1'b0;
		end
		else
		begin
			map_s1 <= mmio_en;
			map_s2 <= map_s1;
		end
	end

	ashs_dev_state_t state;
	ashs_dev_state_t next_state;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	ashs_mv_t held_mv;
	ashs_mv_t next_held_mv;
	ashs_code_t result;
	ashs_code_t next_result;
	logic eoc_n;
	logic next_eoc_n;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic next_sh_hold;
	logic next_adc_busy;
	logic [1:0] chan;
	logic wr_hold;
	logic wr_start;
	logic rd_result;

	always_comb
	begin
		chan = {bus.chan_sel_high, bus.chan_sel_low};
		wr_hold = bus.io_wr && addr_hit(bus.io_addr, bus.io_mem, map_s2, `ASHS_IO_HOLD, `ASHS_MEM_HOLD);
		wr_start = bus.io_wr && addr_hit(bus.io_addr, bus.io_mem, map_s2, `ASHS_IO_START, `ASHS_MEM_START);
		rd_result = bus.io_rd && addr_hit(bus.io_addr, bus.io_mem, map_s2, `ASHS_IO_START, `ASHS_MEM_START);
		next_state = state;
		next_cnt = cnt;
		next_held_mv = held_mv;
		next_result = result;
		next_eoc_n = eoc_n;
		next_rdata = rdata;
		case (state)
			ASHS_TRACK:
			begin
				if (wr_hold)
				begin
					next_held_mv = ain_ok[chan];
					next_state = ASHS_HELD;
				end
				else if (wr_start)
				begin
					// Start without hold converts the live input
					next_held_mv = ain_ok[chan];
					next_cnt = CONV_LOAD;
					next_eoc_n = 1'b1;
					next_state = ASHS_CONV;
				end
			end
			ASHS_HELD:
			begin
				if (wr_start)
				begin
					next_cnt = CONV_LOAD;
					next_eoc_n = 1'b1;
					next_state = ASHS_CONV;
				end
			end
			ASHS_CONV:
			begin
				if (cnt == 16'h0000)
				begin
					next_result = mv_to_code(held_mv);
					next_eoc_n = 1'b0;
					next_state = ASHS_TRACK;
				end
				else
					next_cnt = cnt - 16'h0001;
			end
			default:
				next_state = ASHS_TRACK;
		endcase
		if (rd_result)
			next_rdata = result;
		next_sh_hold = (next_state != ASHS_TRACK);
		next_adc_busy = (next_state == ASHS_CONV);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state <= ASHS_TRACK;
			cnt <= 16'h0000;
			held_mv <= 14'h0000;
			result <= 8'h00;
			eoc_n <= 1'b0;
			rdata <= 8'h00;
			sh_hold <= 1'b0;
			adc_busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			held_mv <= next_held_mv;
			result <= next_result;
			eoc_n <= next_eoc_n;
			rdata <= next_rdata;
			sh_hold <= next_sh_hold;
			adc_busy <= next_adc_busy;
		end
	end

	assign bus.io_rdata = rdata;
	assign bus.port_c_in = 8'(eoc_n) << `ASHS_EOC_BIT;
endmodule

// ===== ashs_host.sv
// Acquisition controller driving the processor bus, with an Avalon-MM register slave
`timescale 1ns/1ns
`include "ashs_params.svh"
module ashs_host
	import ashs_pkg::*;
(
	input wire logic clk, // 50 MHz clock
	input wire logic reset_n, // Synchronous reset
	input wire logic [2:0] avs_address, // Word address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	output logic irq, // Level interrupt
	ashs_bus_if.host bus // Device side
);
	localparam logic [11:0] SETTLE_LOAD = 12'(`ASHS_SETTLE_CYCLES - 1);

	ashs_host_state_t state;
	ashs_host_state_t next_state;
	logic [11:0] cnt;
	logic [11:0] next_cnt;
	logic [1:0] chan;
	logic [1:0] next_chan;
	logic use_mem;
	logic next_use_mem;
	ashs_code_t result;
	ashs_code_t next_result;
	logic int_done;
	logic next_int_done;
	logic mask_done;
	logic next_mask_done;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic next_irq;
	logic [15:0] io_addr;
	logic [15:0] next_io_addr;
	logic io_mem;
	logic next_io_mem;
	logic io_wr;
	logic next_io_wr;
	logic io_rd;
	logic next_io_rd;
	logic acc;
	logic done_evt;

	always_comb
	begin
		acc = (avs_read || avs_write) && !avs_waitrequest;
		next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
		next_readdata = avs_readdata;
		next_state = state;
		next_cnt = cnt;
		next_chan = chan;
		next_use_mem = use_mem;
		next_result = result;
		next_mask_done = mask_done;
		next_io_addr = io_addr;
		next_io_mem = io_mem;
		next_io_wr = 1'b0;
		next_io_rd = 1'b0;
		done_evt = 1'b0;
		case (state)
			ASHS_IDLE:
			begin
				if (acc && avs_write && avs_address == `ASHS_REG_CTRL && avs_writedata[`ASHS_CTRL_GO])
				begin
					next_chan = {avs_writedata[`ASHS_CTRL_CHAN_HI], avs_writedata[`ASHS_CTRL_CHAN_LO]};
					next_use_mem = avs_writedata[`ASHS_CTRL_MEM];
					next_cnt = SETTLE_LOAD;
					next_state = ASHS_SETTLE;
				end
			end
			ASHS_SETTLE:
			begin
				if (cnt == 12'h000)
					next_state = ASHS_HOLD;
				else
					next_cnt = cnt - 12'h001;
			end
			ASHS_HOLD:
			begin
				next_io_wr = 1'b1;
				next_io_mem = use_mem;
				next_io_addr = use_mem ? `ASHS_MEM_HOLD : {`ASHS_IO_HIGH, `ASHS_IO_HOLD};
				next_state = ASHS_START;
			end
			ASHS_START:
			begin
				next_io_wr = 1'b1;
				next_io_addr = use_mem ? `ASHS_MEM_START : {`ASHS_IO_HIGH, `ASHS_IO_START};
				next_state = ASHS_GAP;
			end
			ASHS_GAP:
				next_state = ASHS_POLL;
			ASHS_POLL:
			begin
				if (!bus.port_c_in[`ASHS_EOC_BIT])
				begin
					next_io_rd = 1'b1;
					next_state = ASHS_READ;
				end
			end
			ASHS_READ:
				next_state = ASHS_CAPT;
			ASHS_CAPT:
			begin
				next_result = bus.io_rdata;
				done_evt = 1'b1;
				next_state = ASHS_IDLE;
			end
			default:
				next_state = ASHS_IDLE;
		endcase
		// Set wins over a same-cycle clear
		next_int_done = done_evt || (int_done &&
			!(acc && avs_write && avs_address == `ASHS_REG_INT_STATUS && avs_writedata[`ASHS_INT_DONE]));
		if (acc && avs_write && avs_address == `ASHS_REG_INT_MASK)
			next_mask_done = avs_writedata[`ASHS_INT_DONE];
		if ((avs_read || avs_write) && avs_waitrequest)
		begin
			case (avs_address)
				`ASHS_REG_CTRL: next_readdata = 32'({use_mem, chan, 1'b0});
				`ASHS_REG_STATUS: next_readdata = 32'(state != ASHS_IDLE);
				`ASHS_REG_RESULT: next_readdata = 32'(result);
				`ASHS_REG_INT_STATUS: next_readdata = 32'(int_done);
				`ASHS_REG_INT_MASK: next_readdata = 32'(mask_done);
				default: next_readdata = 32'h0000_0000;
			endcase
		end
		next_irq = next_int_done && next_mask_done;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state <= ASHS_IDLE;
			cnt <= 12'h000;
			chan <= 2'h0;
			use_mem <= 1'b0;
			result <= 8'h00;
			int_done <= 1'b0;
			mask_done <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
			irq <= 1'b0;
			io_addr <= 16'h0000;
			io_mem <= 1'b0;
			io_wr <= 1'b0;
			io_rd <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			chan <= next_chan;
			use_mem <= next_use_mem;
			result <= next_result;
			int_done <= next_int_done;
			mask_done <= next_mask_done;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
			irq <= next_irq;
			io_addr <= next_io_addr;
			io_mem <= next_io_mem;
			io_wr <= next_io_wr;
			io_rd <= next_io_rd;
		end
	end

	assign bus.io_addr = io_addr;
	assign bus.io_mem = io_mem;
	assign bus.io_wr = io_wr;
	assign bus.io_rd = io_rd;
	assign bus.io_wdata = 8'h00;
	assign bus.chan_sel_low = chan[0];
	assign bus.chan_sel_high = chan[1];
endmodule

// ===== ashs_chk.sv
// Interface checker for the sample-and-hold link
`timescale 1ns/1ns
`include "ashs_params.svh"
module ashs_chk #(
	parameter int CONV_CYCLES = `ASHS_CONV_CYCLES
)
(
	input wire logic clk, // Clock
	input wire logic reset_n, // Sync reset
	input wire logic [15:0] io_addr, // Bus address
	input wire logic io_mem, // Memory cycle
	input wire logic io_wr, // Write strobe
	input wire logic io_rd, // Read strobe
	input wire logic [7:0] io_wdata, // Write data
	input wire logic [7:0] io_rdata, // Read data
	input wire logic chan_sel_low, // Channel bit 0
	input wire logic chan_sel_high, // Channel bit 1
	input wire logic [7:0] port_c_in // Port status
);
	logic [12:0] hi_cnt;
	logic [12:0] next_hi_cnt;
	logic [12:0] set_cnt;
	logic [12:0] next_set_cnt;
	logic [1:0] chan_q;
	always_comb
	begin
		next_hi_cnt = port_c_in[4] ? hi_cnt + 13'h1 : 13'h0;
		next_set_cnt = ({chan_sel_high, chan_sel_low} != chan_q) ? 13'h0 : set_cnt + {12'h0, set_cnt != 13'h1FFF};
	end
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			hi_cnt <= 13'h0;
			set_cnt <= 13'h0;
		end
		else
		begin
			hi_cnt <= next_hi_cnt;
			set_cnt <= next_set_cnt;
		end
		chan_q <= {chan_sel_high, chan_sel_low};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_start_eoc: assert property (io_wr && !io_mem && io_addr == 16'h00A0 && !port_c_in[4] |=> port_c_in[4])
		else $error("start did not raise eoc");
	a_eoc_bound: assert property (port_c_in[4] |-> hi_cnt < CONV_CYCLES)
		else $error("conversion too long");
	a_eoc_length: assert property ($fell(port_c_in[4]) |-> hi_cnt == CONV_CYCLES)
		else $error("conversion length wrong");
	a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data changed without read");
	a_start_follows: assert property (io_wr && io_addr[7:0] == 8'h90 |=> io_wr && io_addr[7:0] == 8'hA0
		&& io_mem == $past(io_mem))
		else $error("start did not follow hold");
	a_settle_wait: assert property (io_wr && io_addr[7:0] == 8'h90 |-> set_cnt >= 13'h05DB)
		else $error("hold before settle time");
	a_read_soon: assert property ($fell(port_c_in[4]) |-> ##[1:8] io_rd)
		else $error("result not read after eoc");
	a_read_done: assert property (io_rd |-> !port_c_in[4] && io_addr[7:0] == 8'hA0)
		else $error("read while converting");
	a_map_space: assert property (io_wr || io_rd |-> io_addr[15:8] == (io_mem ? 8'h60 : 8'h00))
		else $error("bad address space");
	cover property ($fell(port_c_in[4]));
	cover property (io_wr && io_mem);
	cover property (io_rd ##1 io_rdata == 8'hFF);
endmodule

// ===== test_adc_sample_hold_sequencer.sv
// Testbench joining host and device across the bus interface
`timescale 1ns/1ns
module test_adc_sample_hold_sequencer;
	logic clk, reset_n, avs_read, avs_write, mmio_en, irq, avs_waitrequest, sh_hold, adc_busy;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0][13:0] ain_mv;
	int mismatches, checked;
	ashs_bus_if bus();
	ashs_host ashs_host_inst(.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .bus(bus));
	ashs_device #(.CONV_CYCLES(20)) ashs_device_inst(.clk(clk), .reset_n(reset_n), .bus(bus), .ain_mv(ain_mv),
		.mmio_en(mmio_en), .sh_hold(sh_hold), .adc_busy(adc_busy));
	ashs_chk #(.CONV_CYCLES(20)) ashs_chk_inst(.clk(clk), .reset_n(reset_n), .io_addr(bus.io_addr),
		.io_mem(bus.io_mem), .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata),
		.chan_sel_low(bus.chan_sel_low), .chan_sel_high(bus.chan_sel_high), .port_c_in(bus.port_c_in));
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] code_of(input logic [13:0] mv);
		int c;
		c = (mv <= 14'h03E8) ? 0 : (int'(mv) - 1000) / 20;
		return (c > 255) ? 8'hFF : c[7:0];
	endfunction
	// Avalon access: hold the request until waitrequest is seen low
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge clk);
		// Only the watchdog ends a wait that never gets an answer
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic regs_after_reset();
		check("idle pins", {irq, bus.port_c_in}, 32'h0);
		av(1'b1, 3'h6, 32'hFFFFFFFF);
		for (int a = 0; a < 7; a++)
		begin
			av(1'b0, a[2:0], 32'h0);
			check("reset reg", rd, 32'h0);
		end
	endtask
	task automatic convert(input logic [1:0] ch, input logic mem);
		logic [2:0] seen;
		seen = 3'h0;
		av(1'b1, 3'h0, {28'h0, mem, ch, 1'b1});
		// Second GO lands while busy and must not start another run
		av(1'b1, 3'h0, {28'h0, mem, ch, 1'b1});
		av(1'b0, 3'h0, 32'h0);
		check("ctrl", rd, {28'h0, mem, ch, 1'b0});
		check("select pins", {30'h0, bus.chan_sel_high, bus.chan_sel_low}, {30'h0, ch});
		av(1'b0, 3'h1, 32'h0);
		check("busy", rd, 32'h1);
		// Polling every third cycle still catches the twenty-cycle conversion window
		while (rd[0] === 1'b1)
		begin
			seen = seen | {sh_hold, adc_busy, bus.port_c_in[4]};
			av(1'b0, 3'h1, 32'h0);
		end
		check("hold busy eoc seen", {29'h0, seen}, 32'h7);
		check("back to track", {sh_hold, adc_busy, bus.port_c_in[4]}, 32'h0);
		av(1'b0, 3'h2, 32'h0);
		check("result", rd, {24'h0, code_of(ain_mv[ch])});
		av(1'b0, 3'h1, 32'h0);
		check("no rerun", rd, 32'h0);
	endtask
	// Memory cycles with the option strap off must leave the converter alone
	task automatic mem_refused(input logic [1:0] ch, input logic [7:0] stale);
		logic seen;
		seen = 1'b0;
		av(1'b1, 3'h0, {28'h0, 1'b1, ch, 1'b1});
		rd = 32'h1;
		while (rd[0] === 1'b1)
		begin
			seen = seen | sh_hold | bus.port_c_in[4];
			av(1'b0, 3'h1, 32'h0);
		end
		check("refused hold", {31'h0, seen}, 32'h0);
		av(1'b0, 3'h2, 32'h0);
		check("stale result", rd, {24'h0, stale});
	endtask
	task automatic irq_flow();
		check("irq masked", {31'h0, irq}, 32'h0);
		av(1'b0, 3'h3, 32'h0);
		check("done sticky", rd, 32'h1);
		av(1'b1, 3'h4, 32'h1);
		repeat (2) @(posedge clk);
		check("irq on", {31'h0, irq}, 32'h1);
		av(1'b1, 3'h3, 32'h1);
		repeat (2) @(posedge clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		av(1'b0, 3'h3, 32'h0);
		check("done cleared", rd, 32'h0);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run is about ten thousand cycles
	initial
	begin
		#1000000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		reset_n = 1'b0;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		mmio_en = 1'b0;
		ain_mv = {14'h2328, 14'h17D3, 14'h040F, 14'h03E8};
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		regs_after_reset();
		for (int c = 0; c < 4; c++)
			convert(c[1:0], 1'b0);
		irq_flow();
		mmio_en <= 1'b1;
		repeat (4) @(posedge clk);
		convert(2'h2, 1'b1);
		convert(2'h1, 1'b0);
		mmio_en <= 1'b0;
		repeat (4) @(posedge clk);
		mem_refused(2'h0, code_of(ain_mv[1]));
		give_verdict();
	end
endmodule
